// >>> esc_top.sv
// esc_top: sense control, status flags and AXI4-Lite registers for 16 irq inputs
// assumes pins are asynchronous, exc_ack comes from logic on aclk
//
// Function
// (R1) Each input has a two-bit field, upper bit odd position, lower bit just below.
// (R2) Field 00 requests an interrupt while the selected pin is low.
// (R3) Field 01 requests an interrupt on a falling edge of the selected pin.
// (R4) Field 10 requests an interrupt on a rising edge of the selected pin.
// (R5) Field 11 requests an interrupt on both edges of the selected pin.
// (R6) Fields act on all primary pins and alternates from 6 up; 3..0 use primary only.
// (R7) Inputs 15..8 sense the pin chosen by the upper pin select.
// (R8) Inputs 7 and 6 sense the pin chosen by the lower pin select.
// (R9) Inputs 5 and 4 have no alternate pin and always sense the primary.
// (R10) Sense registers hold 15..12, 11..8, 7..4, 3..0, higher inputs in higher bits.
// (R11) All sense fields reset to zero, low-level sensing.
// (R12) The chosen condition sets the input's status flag.
// (R13) Writing zero after reading one clears a flag; writing one leaves it.
// (R14) Exception handling clears a flag in edge modes, or in level mode if pin is high.
// (R15) A request reaches the processor only while its enable bit is one.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module esc_top
    import esc_pkg::*;
(
    input  wire logic              aclk,          // system clock
    input  wire logic              aresetn,       // sync reset, active low
    input  wire logic              ce,            // clock enable
    input  wire logic [ADDR_W-1:0] awaddr,        // write address
    input  wire logic              awvalid,       // write address valid
    output logic                   awready,       // write address ready
    input  wire logic [31:0]       wdata,         // write data
    input  wire logic [3:0]        wstrb,         // write strobes
    input  wire logic              wvalid,        // write data valid
    output logic                   wready,        // write data ready
    output logic [1:0]             bresp,         // write response
    output logic                   bvalid,        // write response valid
    input  wire logic              bready,        // write response ready
    input  wire logic [ADDR_W-1:0] araddr,        // read address
    input  wire logic              arvalid,       // read address valid
    output logic                   arready,       // read address ready
    output logic [31:0]            rdata,         // read data
    output logic [1:0]             rresp,         // read response
    output logic                   rvalid,        // read data valid
    input  wire logic              rready,        // read data ready
    input  wire logic [NIRQ-1:0]   primary_interrupt_pin,          // primary pins
    input  wire logic [NIRQ-1:ALT_LO] alternate_interrupt_pin,     // alternate pins
    input  wire logic [NIRQ-1:0]   exc_ack,       // exception handled, pulse
    output logic [NIRQ-1:0]        irq_req,       // enabled requests
    output logic                   irq            // any enabled request
);
    logic [REG_W-1:0]    sense_uh_q, sense_ul_q, sense_lh_q, sense_ll_q;
    logic [NIRQ-1:0]     en_q, flag_q, seen_q;
    logic [REG_W-1:0]    sel_up_q, sel_lo_q;
    logic [NIRQ-1:0]     prim_s1_q, prim_s2_q, pin_prev_q;
    logic [NIRQ-1:ALT_LO] alt_s1_q, alt_s2_q;
    logic [NIRQ-1:0]     pin, set_ev, clr_ev, clr_wr, rd_stat;
    logic [4*REG_W-1:0]  sense_all;
    logic                aw_have_q, w_have_q;
    logic [ADDR_W-1:0]   aw_addr_q;
    logic [REG_W-1:0]    w_byte_q;
    logic                w_lane_q;
    logic                do_wr, do_rd, rd_err;
    logic [REG_W-1:0]    rd_d;

    assign sense_all = {sense_uh_q, sense_ul_q, sense_lh_q, sense_ll_q}; // [R10]

    // pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // pins idle high, so no false level or edge after reset
            prim_s1_q  <= '1;
            prim_s2_q  <= '1;
            alt_s1_q   <= '1;
            alt_s2_q   <= '1;
            pin_prev_q <= '1;
        end else if (ce) begin
            prim_s1_q  <= primary_interrupt_pin;
            prim_s2_q  <= prim_s1_q;
            alt_s1_q   <= alternate_interrupt_pin;
            alt_s2_q   <= alt_s1_q;
            pin_prev_q <= pin;
        end
    end

    // write channel capture
    assign do_wr = aw_have_q && w_have_q && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_addr_q <= '0;
            w_byte_q  <= '0;
            w_lane_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awready   <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wready   <= 1'b0;
                w_byte_q <= wdata[REG_W-1:0];
                w_lane_q <= wstrb[0];
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    function automatic logic wr_ok(input logic [ADDR_W-1:0] a);
        wr_ok = (a <= OFF_SEL_LO) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = do_wr && w_lane_q && (aw_addr_q == a);
    endfunction

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_uh_q <= REG_RST;   // [R11]
            sense_ul_q <= REG_RST;   // [R11]
            sense_lh_q <= REG_RST;   // [R11]
            sense_ll_q <= REG_RST;   // [R11]
            en_q       <= '0;
            sel_up_q   <= REG_RST;
            sel_lo_q   <= REG_RST;
        end else if (ce) begin
            if (hit(OFF_SENSE_UH)) sense_uh_q <= w_byte_q;
            if (hit(OFF_SENSE_UL)) sense_ul_q <= w_byte_q;
            if (hit(OFF_SENSE_LH)) sense_lh_q <= w_byte_q;
            if (hit(OFF_SENSE_LL)) sense_ll_q <= w_byte_q;
            if (hit(OFF_EN_UP)) en_q[NIRQ-1:SPLIT] <= w_byte_q;
            if (hit(OFF_EN_LO)) en_q[SPLIT-1:0] <= w_byte_q;
            if (hit(OFF_SEL_UP)) sel_up_q <= w_byte_q;
            if (hit(OFF_SEL_LO)) sel_lo_q <= w_byte_q & SEL_LO_MASK;
        end
    end

    // zero written to a flag already read as one clears it
    always_comb begin
        clr_wr = '0;
        if (hit(OFF_STAT_UP))
            clr_wr[NIRQ-1:SPLIT] = ~w_byte_q & seen_q[NIRQ-1:SPLIT];  // [R13]
        if (hit(OFF_STAT_LO))
            clr_wr[SPLIT-1:0] = ~w_byte_q & seen_q[SPLIT-1:0];        // [R13]
    end

    // read channel
    assign do_rd = arvalid && arready;
    always_comb begin
        rd_d    = '0;
        rd_err  = 1'b0;
        rd_stat = '0;
        case (araddr)
            OFF_SENSE_UH: rd_d = sense_uh_q;
            OFF_SENSE_UL: rd_d = sense_ul_q;
            OFF_SENSE_LH: rd_d = sense_lh_q;
            OFF_SENSE_LL: rd_d = sense_ll_q;
            OFF_EN_UP:    rd_d = en_q[NIRQ-1:SPLIT];
            OFF_EN_LO:    rd_d = en_q[SPLIT-1:0];
            OFF_STAT_UP: begin
                rd_d = flag_q[NIRQ-1:SPLIT];
                rd_stat[NIRQ-1:SPLIT] = {REG_W{do_rd}};
            end
            OFF_STAT_LO: begin
                rd_d = flag_q[SPLIT-1:0];
                rd_stat[SPLIT-1:0] = {REG_W{do_rd}};
            end
            OFF_SEL_UP:   rd_d = sel_up_q;
            OFF_SEL_LO:   rd_d = sel_lo_q;
            default:      rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (do_rd) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= {{(32-REG_W){1'b0}}, rd_d};
                rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // per-input pin choice, detection and flag
    for (genvar i = 0; i < NIRQ; i++) begin : g_in
        logic [FLD_W-1:0] mode;
        assign mode = sense_all[FLD_W*i +: FLD_W];                     // [R1]
        if (i >= SPLIT) begin : g_up
            assign pin[i] = sel_up_q[i-SPLIT] ? alt_s2_q[i] : prim_s2_q[i]; // [R6] [R7]
        end else if (i >= ALT_LO) begin : g_lo
            assign pin[i] = sel_lo_q[i] ? alt_s2_q[i] : prim_s2_q[i];  // [R8]
        end else begin : g_prim
            assign pin[i] = prim_s2_q[i];                              // [R6] [R9]
        end
        always_comb begin
            case (mode)
                SENSE_LOW:  set_ev[i] = !pin[i];                       // [R2]
                SENSE_FALL: set_ev[i] = pin_prev_q[i] && !pin[i];      // [R3]
                SENSE_RISE: set_ev[i] = !pin_prev_q[i] && pin[i];      // [R4]
                SENSE_BOTH: set_ev[i] = pin_prev_q[i] != pin[i];       // [R5]
                default:    set_ev[i] = 1'b0;
            endcase
        end
        assign clr_ev[i] = clr_wr[i] ||
                           (exc_ack[i] && (mode != SENSE_LOW || pin[i])); // [R14]
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                flag_q[i] <= 1'b0;
                seen_q[i] <= 1'b0;
            end else if (ce) begin
                if (set_ev[i])
                    flag_q[i] <= 1'b1;                                 // [R12]
                else if (clr_ev[i])
                    flag_q[i] <= 1'b0;                                 // [R13] [R14]
                if (clr_ev[i])
                    seen_q[i] <= 1'b0;
                else if (rd_stat[i] && flag_q[i])
                    seen_q[i] <= 1'b1;                                 // [R13]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req <= '0;
            irq     <= 1'b0;
        end else if (ce) begin
            irq_req <= flag_q & en_q;                                  // [R15]
            irq     <= |(flag_q & en_q);                               // [R15]
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_low;
        ce && sense_ll_q[1:0] == SENSE_LOW && !pin[0] |=> flag_q[0];
    endproperty
    a_low: assert property (p_low) else $error("low level did not set flag"); // [R2]

    property p_fall;
        ce && sense_uh_q[3:2] == SENSE_FALL && pin_prev_q[13] && !pin[13] |=> flag_q[13];
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge missed"); // [R3]

    property p_rise;
        ce && sense_lh_q[7:6] == SENSE_RISE && !pin_prev_q[7] && pin[7] |=> flag_q[7];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // [R4]

    property p_nofall;
        ce && sense_lh_q[7:6] == SENSE_RISE && pin_prev_q[7] && !pin[7] && !flag_q[7]
            |=> !flag_q[7];
    endproperty
    a_nofall: assert property (p_nofall) else $error("falling edge set rise flag"); // [R4]

    property p_both;
        ce && sense_ul_q[3:2] == SENSE_BOTH && pin_prev_q[9] != pin[9] |=> flag_q[9];
    endproperty
    a_both: assert property (p_both) else $error("edge missed in both mode"); // [R5]

    property p_prim5;
        pin[5] == prim_s2_q[5] && pin[4] == prim_s2_q[4];
    endproperty
    a_prim5: assert property (p_prim5) else $error("input 5 or 4 left primary"); // [R9]

    property p_rst;
        disable iff (1'b0) !aresetn |=> sense_all == '0 && flag_q == '0;
    endproperty
    a_rst: assert property (@(posedge aclk) p_rst) else $error("sense not reset"); // [R11]

    property p_one;
        ce && hit(OFF_STAT_LO) && w_byte_q[0] && flag_q[0] && !exc_ack[0] |=> flag_q[0];
    endproperty
    a_one: assert property (p_one) else $error("writing one cleared flag"); // [R13]

    property p_irq;
        ce |=> irq == $past(|(flag_q & en_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq not tied to flags"); // [R15]

    property p_ack;
        ce && exc_ack[0] && sense_ll_q[1:0] != SENSE_LOW && !set_ev[0] |=> !flag_q[0];
    endproperty
    a_ack: assert property (p_ack) else $error("edge flag not cleared by ack"); // [R14]

    c_level: cover property (ce && !flag_q[0] ##1 flag_q[0]);
    c_clear: cover property (ce && clr_wr[0] && flag_q[0]);
    c_both:  cover property (ce && sense_ul_q[3:2] == SENSE_BOTH && set_ev[9]);
    c_irq:   cover property (!irq ##1 irq);
endmodule

// >>> esc_pkg.sv
// esc_pkg: constants for the external interrupt sense-control block
// assumes a 32-bit AXI4-Lite bus with registers in the low byte lane
package esc_pkg;
    localparam int          NIRQ    = 16;
    localparam int          ALT_LO  = 6;     // lowest input with an alternate pin
    localparam int          SPLIT   = 8;     // inputs at or above use upper select
    localparam int          FLD_W   = 2;
    localparam int          REG_W   = 8;
    localparam int          ADDR_W  = 6;
    localparam logic [5:0]  OFF_SENSE_UH = 6'h00;
    localparam logic [5:0]  OFF_SENSE_UL = 6'h04;
    localparam logic [5:0]  OFF_SENSE_LH = 6'h08;
    localparam logic [5:0]  OFF_SENSE_LL = 6'h0C;
    localparam logic [5:0]  OFF_EN_UP    = 6'h10;
    localparam logic [5:0]  OFF_EN_LO    = 6'h14;
    localparam logic [5:0]  OFF_STAT_UP  = 6'h18;
    localparam logic [5:0]  OFF_STAT_LO  = 6'h1C;
    localparam logic [5:0]  OFF_SEL_UP   = 6'h20;
    localparam logic [5:0]  OFF_SEL_LO   = 6'h24;
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [7:0]  SEL_LO_MASK  = 8'hC0; // only inputs 7 and 6 selectable
    localparam logic [1:0]  SENSE_LOW    = 2'h0;
    localparam logic [1:0]  SENSE_FALL   = 2'h1;
    localparam logic [1:0]  SENSE_RISE   = 2'h2;
    localparam logic [1:0]  SENSE_BOTH   = 2'h3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// >>> esc_pin_model.sv
// esc_pin_model: board-side drivers for the primary and alternate interrupt pins
// assumes one clock; pins idle high behind pull-ups and change right after a rising edge
`timescale 1ns/100ps
module esc_pin_model
    import esc_pkg::*;
(
    input  wire logic              aclk,                    // system clock
    output logic [NIRQ-1:0]        primary_interrupt_pin,   // primary pins
    output logic [NIRQ-1:ALT_LO]   alternate_interrupt_pin  // alternate pins
);
    initial begin
        primary_interrupt_pin   = '1;
        alternate_interrupt_pin = '1;
    end

    // move one pin, primary or alternate, just after an edge
    task automatic drive(input int n, input bit use_alt, input logic lvl);
        @(posedge aclk);
        if (use_alt) begin
            alternate_interrupt_pin[n] <= lvl;
        end else begin
            primary_interrupt_pin[n] <= lvl;
        end
    endtask
endmodule

// >>> test_external_irq_sense_control.sv
// test_external_irq_sense_control: self-checking bench for the sense-control block
// assumes esc_pkg, esc_top and esc_pin_model are compiled first
`timescale 1ns/100ps
module test_external_irq_sense_control;
    import esc_pkg::*;
    logic              aclk    = 1'b0;
    logic              aresetn = 1'b0;
    logic              ce      = 1'b1;
    logic [5:0]        awaddr  = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [31:0]       wdata   = '0;
    logic              wvalid  = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready  = 1'b0;
    logic [5:0]        araddr  = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready  = 1'b0;
    logic [15:0]       primary_interrupt_pin;
    logic [15:6]       alternate_interrupt_pin;
    logic [15:0]       exc_ack = '0;
    logic [15:0]       irq_req;
    logic              irq;
    int                fails     = 0;
    int                tests_run = 0;

    always #25 aclk = ~aclk;

    esc_pin_model pins (.aclk(aclk), .primary_interrupt_pin(primary_interrupt_pin),
        .alternate_interrupt_pin(alternate_interrupt_pin));

    esc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .primary_interrupt_pin(primary_interrupt_pin),
        .alternate_interrupt_pin(alternate_interrupt_pin), .exc_ack(exc_ack),
        .irq_req(irq_req), .irq(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        int k;
        r = 2'h3;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h000000, d};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (k == 50) fails++;
    endtask

    task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
        int k;
        r = 2'h3;
        v = 'x;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (k == 50) fails++;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic [31:0] v;
        logic [1:0]  r;
        axi_rd(a, v, r);
        check(v, {24'h000000, exp});
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    // every sense mode on one input: fall, software clear, rise, exception clear, mask
    task automatic sense_case(input int n, input bit use_alt);
        logic [5:0] sa;
        logic [5:0] st;
        logic [5:0] en;
        logic [7:0] b;
        logic [15:0] rq;
        int m;
        sa = OFF_SENSE_LL - 6'(4 * (n / 4));
        st = (n >= SPLIT) ? OFF_STAT_UP : OFF_STAT_LO;
        en = (n >= SPLIT) ? OFF_EN_UP : OFF_EN_LO;
        b  = 8'h01 << (n % 8);
        rq = 16'h0001 << n;
        wr(en, b);
        for (m = 0; m < 4; m++) begin
            wr(sa, 8'(m << (2 * (n % 4))));
            rd(sa, 8'(m << (2 * (n % 4))));
            rd(st, 8'h00);
            pins.drive(n, use_alt, 1'b0);
            repeat (6) @(posedge aclk);
            wr(st, 8'hFF);
            rd(st, (m != 2) ? b : 8'h00);
            check({irq, irq_req}, (m != 2) ? {1'b1, rq} : 17'h0);
            wr(st, 8'h00);
            rd(st, (m == 0) ? b : 8'h00);
            pins.drive(n, use_alt, 1'b1);
            repeat (6) @(posedge aclk);
            rd(st, (m == 0 || m >= 2) ? b : 8'h00);
            @(posedge aclk);
            exc_ack <= rq;
            @(posedge aclk);
            exc_ack <= 16'h0000;
            rd(st, 8'h00);
        end
        wr(en, 8'h00);
        pins.drive(n, use_alt, 1'b0);
        repeat (6) @(posedge aclk);
        rd(st, b);
        check({irq, irq_req}, 17'h0);
        pins.drive(n, use_alt, 1'b1);
        repeat (6) @(posedge aclk);
        exc_ack <= rq;
        @(posedge aclk);
        exc_ack <= 16'h0000;
        rd(st, 8'h00);
    endtask

    task automatic print_verdict;
        $display("tests run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        fails++;
        print_verdict();
    end

    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({irq, irq_req}, 17'h0);
        rd(OFF_SENSE_UH, REG_RST);
        rd(OFF_SENSE_UL, REG_RST);
        rd(OFF_SENSE_LH, REG_RST);
        rd(OFF_SENSE_LL, REG_RST);
        wr(OFF_SENSE_UH, 8'h1B);
        wr(OFF_SENSE_LL, 8'hE4);
        rd(OFF_SENSE_UH, 8'h1B);
        rd(OFF_SENSE_UL, 8'h00);
        rd(OFF_SENSE_LL, 8'hE4);
        axi_wr(6'h30, 8'h55, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_rd(6'h02, v, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        sense_case(0, 1'b0);
        sense_case(9, 1'b0);
        wr(OFF_SEL_UP, 8'h20);
        sense_case(13, 1'b1);
        wr(OFF_SEL_LO, 8'hFF);
        rd(OFF_SEL_LO, SEL_LO_MASK);
        sense_case(7, 1'b1);
        sense_case(5, 1'b0);
        print_verdict();
    end
endmodule
